/* File: hdl/nvm_cfg.svh */
/*
 * Constants of the serial nonvolatile memory slave: array geometry, slave
 * address field positions, reset values and serial clock timing.
 * Assumes it is included by bare name and that nothing else defines NVM_ names.
 */
`ifndef NVM_CFG_SVH
`define NVM_CFG_SVH

// array geometry
`define NVM_DEPTH          512
`define NVM_ADDR_W         9
`define NVM_DATA_W         8
`define NVM_WORD_ADDR_W    8

// slave address byte layout
`define NVM_TYPE_MSB       7
`define NVM_TYPE_LSB       4
`define NVM_SEL_MSB        3
`define NVM_SEL_LSB        2
`define NVM_PAGE_BIT       1
`define NVM_RW_BIT         0

// reset values and the last bit count
`define NVM_ADDR_RST       9'h000
`define NVM_CNT_RST        3'h0
`define NVM_LAST_BIT       3'h7

// timing: fastest serial clock and the cycles it leaves per half period
`define NVM_CLK_MHZ        25
`define NVM_SCL_MAX_KHZ    1000
`define NVM_SCL_HALF_NS    500
`define NVM_SCL_HALF_CYC   ((`NVM_SCL_HALF_NS * `NVM_CLK_MHZ) / 1000)
`define NVM_MIN_HALF_CYC   4

`endif

/* File: hdl/nvm_pkg.sv */
/*
 * Types of the serial nonvolatile memory slave: bus state machine states,
 * the bundle of synchronised pins and the array write port.
 * Assumes nvm_cfg.svh is on the include path.
 */
`include "nvm_cfg.svh"

package nvm_pkg;

    // bus state machine
    typedef enum logic [3:0] {
        NVM_ST_IDLE     = 4'h0,
        NVM_ST_ADDR     = 4'h1,
        NVM_ST_WORD     = 4'h2,
        NVM_ST_WDATA    = 4'h3,
        NVM_ST_ACK      = 4'h4,
        NVM_ST_ACK_HOLD = 4'h5,
        NVM_ST_RDATA    = 4'h6,
        NVM_ST_RACK     = 4'h7,
        NVM_ST_RLOAD    = 4'h8
    } nvm_state_e;

    // pins after the synchroniser
    typedef struct packed {
        logic       scl;
        logic       sda;
        logic       wp;
        logic [1:0] sel;
    } nvm_pins_s;

    // write port of the storage array
    typedef struct packed {
        logic                     en;
        logic [`NVM_ADDR_W-1:0]   addr;
        logic [`NVM_DATA_W-1:0]   data;
    } nvm_wr_s;

endpackage

/* File: hdl/nvm_sync.sv */
/*
 * Two flip-flop synchroniser for a group of asynchronous pin levels.
 * Assumes inputs are slow levels from outside the clk domain.
 */
`timescale 1ns/1ps

module nvm_sync #(
    parameter int WIDTH = 5
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] async_in,
    input  wire logic [WIDTH-1:0] rst_val,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    generate
        if (WIDTH < 1) begin
            $error("nvm_sync: WIDTH must be at least 1");
        end
    endgenerate

    // first stage feeds only the second stage; reset loads the idle levels
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_q   <= rst_val;
            sync_out <= rst_val;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

/* File: hdl/nvm_mem.sv */
/*
 * Storage array of the memory slave: one write port, one read port with
 * registered read data.
 * Assumes a write and a read in the same cycle return the old data.
 */
`timescale 1ns/1ps

module nvm_mem #(
    parameter int DEPTH  = 512,
    parameter int ADDR_W = 9,
    parameter int DATA_W = 8
) (
    input  wire logic              clk,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [DATA_W-1:0] rd_data
);

    logic [DATA_W-1:0] cell_q [DEPTH];

    generate
        if (DEPTH > (1 << ADDR_W) || DEPTH < 1) begin
            $error("nvm_mem: DEPTH does not fit ADDR_W");
        end
    endgenerate

    // byte stored in the cycle it is presented
    always_ff @(posedge clk) begin
        if (wr_en) begin
            cell_q[wr_addr] <= wr_data;
        end
    end

    // registered read
    always_ff @(posedge clk) begin
        rd_data <= cell_q[rd_addr];
    end

endmodule

/* File: hdl/nvm_slave.sv */
/*
 * Two-wire serial bus slave in front of a 512 x 8 nonvolatile array.
 * Decodes start and stop, the slave address, the word address and data
 * bytes, acknowledges, streams sequential reads and stores writes at once.
 * Assumes the serial clock and data, the write-protect pin and the select
 * pins arrive asynchronously, that the pad pull-downs bring unconnected pins
 * to low, and that the pad turns sda_oe into a pull-down of the wire.
 */
`timescale 1ns/1ps

`include "nvm_cfg.svh"

// Operation
// - answer only when select bits match pins
// - unconnected select pins read as low
// - data line open drain, low or released
// - drive after falling edge, sample on rising
// - write protect high blocks every array write
// - unconnected write protect reads as low
// - 512 bytes, eight bits shifted serially each
// - word address selects one of 256
// - page bit above word address, nine bits
// - byte stored right after its last bit
// - write done before next transaction starts
// - serial clock up to 1 MHz supported
// - interface state set only by reset
// - slave byte: type, select, page, direction
// - address increments before ack, wraps to zero
// - reads continue while master acknowledges
// - writes carry word address, reads do not
module nvm_slave
    import nvm_pkg::*;
#(
    parameter logic [3:0] DEV_TYPE = 4'h5,   // device type code, value arbitrary
    parameter int         DEPTH    = `NVM_DEPTH,
    parameter int         ADDR_W   = `NVM_ADDR_W
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       wp_in,
    input  wire logic [1:0] device_select_pins
);

    localparam int DATA_W = `NVM_DATA_W;
    localparam int WORD_W = `NVM_WORD_ADDR_W;
    // idle bus levels, so no false edge or condition follows reset
    localparam nvm_pins_s PINS_IDLE = '{scl: 1'b1, sda: 1'b1, wp: 1'b0, sel: 2'b00};

    // elaboration checks on geometry and clock ratio
    generate
        if (ADDR_W != WORD_W + 1) begin
            $error("nvm_slave: ADDR_W must be word address plus one page bit");
        end
        if (DEPTH != (1 << ADDR_W)) begin
            $error("nvm_slave: DEPTH must fill the whole address range");
        end
        if (`NVM_SCL_HALF_CYC < `NVM_MIN_HALF_CYC) begin
            $error("nvm_slave: clk too slow for the fastest serial clock");
        end
    endgenerate

    // address latch step with wrap from the top location to zero
    function automatic logic [ADDR_W-1:0] addr_next(input logic [ADDR_W-1:0] a);
        addr_next = a + {{(ADDR_W-1){1'b0}}, 1'b1};
    endfunction

    nvm_pins_s                raw_pins;
    nvm_pins_s                pins;
    nvm_wr_s                  wr;
    nvm_state_e               state_q;
    nvm_state_e               state_d;
    nvm_state_e               ret_q;
    nvm_state_e               ret_d;
    logic                     scl_prev_q;
    logic                     sda_prev_q;
    logic [2:0]               cnt_q;
    logic [2:0]               cnt_d;
    logic [DATA_W-1:0]        shift_q;
    logic [DATA_W-1:0]        shift_d;
    logic [DATA_W-1:0]        tx_q;
    logic [DATA_W-1:0]        tx_d;
    logic [ADDR_W-1:0]        addr_q;
    logic [ADDR_W-1:0]        addr_d;
    logic                     page_q;
    logic                     page_d;
    logic                     oe_q;
    logic                     oe_d;
    logic [DATA_W-1:0]        rd_data;

    // pin bundle; pad pull-downs give low on open pins
    assign raw_pins.scl = scl_in;
    assign raw_pins.sda = sda_in;
    assign raw_pins.wp  = wp_in;
    assign raw_pins.sel = device_select_pins;

    // every pin passes two flip-flops before use
    nvm_sync #(
        .WIDTH    ($bits(nvm_pins_s))
    ) u_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in (raw_pins),
        .rst_val  (PINS_IDLE),
        .sync_out (pins)
    );

    // previous levels for edge and condition detection
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= pins.scl;
            sda_prev_q <= pins.sda;
        end
    end

    // clock edges and bus conditions; the sampled clock serves up to 1 MHz
    wire scl_rise  = pins.scl & ~scl_prev_q;
    wire scl_fall  = ~pins.scl & scl_prev_q;
    wire bus_start = pins.scl & scl_prev_q & sda_prev_q & ~pins.sda;
    wire bus_stop  = pins.scl & scl_prev_q & ~sda_prev_q & pins.sda;

    // incoming byte with the bit of this rising edge, msb first
    wire [DATA_W-1:0] byte_in  = {shift_q[DATA_W-2:0], pins.sda};
    wire              last_bit = scl_rise & (cnt_q == `NVM_LAST_BIT);
    wire [2:0]        cnt_inc  = cnt_q + 3'h1;

    // slave address fields
    wire [3:0] sa_type = byte_in[`NVM_TYPE_MSB:`NVM_TYPE_LSB];
    wire [1:0] sa_sel  = byte_in[`NVM_SEL_MSB:`NVM_SEL_LSB];
    wire       sa_page = byte_in[`NVM_PAGE_BIT];
    wire       sa_read = byte_in[`NVM_RW_BIT];
    wire       sa_hit  = (sa_type == DEV_TYPE) & (sa_sel == pins.sel);

    // full byte address: page bit above the word address
    wire [ADDR_W-1:0] word_addr = {page_q, byte_in};
    wire [ADDR_W-1:0] read_addr = {sa_page, addr_q[WORD_W-1:0]};
    wire [ADDR_W-1:0] addr_inc  = addr_next(addr_q);

    // array write, gated by the protect pin, at the last bit of a data byte
    assign wr.en   = (state_q == NVM_ST_WDATA) & last_bit & ~pins.wp;
    assign wr.addr = addr_q;
    assign wr.data = byte_in;

    // bus state machine, start and stop override any state
    always_comb begin
        state_d = state_q;
        ret_d   = ret_q;
        cnt_d   = cnt_q;
        shift_d = shift_q;
        tx_d    = tx_q;
        addr_d  = addr_q;
        page_d  = page_q;
        oe_d    = oe_q;
        if (bus_start) begin
            state_d = NVM_ST_ADDR;
            cnt_d   = `NVM_CNT_RST;
            oe_d    = 1'b0;
        end else if (bus_stop) begin
            state_d = NVM_ST_IDLE;
            oe_d    = 1'b0;
        end else begin
            case (state_q)
                NVM_ST_IDLE: begin
                    oe_d = 1'b0;
                end
                NVM_ST_ADDR: begin
                    if (scl_rise) begin
                        shift_d = byte_in;
                        cnt_d   = cnt_inc;
                    end
                    if (last_bit) begin
                        if (sa_hit) begin
                            state_d = NVM_ST_ACK;
                            page_d  = sa_page;
                            if (sa_read) begin
                                addr_d = read_addr;
                                ret_d  = NVM_ST_RDATA;
                            end else begin
                                ret_d  = NVM_ST_WORD;
                            end
                        end else begin
                            state_d = NVM_ST_IDLE;
                        end
                    end
                end
                NVM_ST_WORD: begin
                    if (scl_rise) begin
                        shift_d = byte_in;
                        cnt_d   = cnt_inc;
                    end
                    if (last_bit) begin
                        addr_d  = word_addr;
                        ret_d   = NVM_ST_WDATA;
                        state_d = NVM_ST_ACK;
                    end
                end
                NVM_ST_WDATA: begin
                    if (scl_rise) begin
                        shift_d = byte_in;
                        cnt_d   = cnt_inc;
                    end
                    if (last_bit) begin
                        addr_d  = addr_inc;
                        ret_d   = NVM_ST_WDATA;
                        state_d = NVM_ST_ACK;
                    end
                end
                NVM_ST_ACK: begin
                    if (scl_fall) begin
                        oe_d    = 1'b1;
                        state_d = NVM_ST_ACK_HOLD;
                    end
                end
                NVM_ST_ACK_HOLD: begin
                    if (scl_fall) begin
                        cnt_d   = `NVM_CNT_RST;
                        state_d = ret_q;
                        if (ret_q == NVM_ST_RDATA) begin
                            tx_d = rd_data;
                            oe_d = ~rd_data[DATA_W-1];
                        end else begin
                            oe_d = 1'b0;
                        end
                    end
                end
                NVM_ST_RDATA: begin
                    if (scl_fall) begin
                        tx_d = {tx_q[DATA_W-2:0], 1'b0};
                        oe_d = ~tx_q[DATA_W-2];
                    end
                    if (scl_rise) begin
                        cnt_d = cnt_inc;
                    end
                    if (last_bit) begin
                        addr_d  = addr_inc;
                        state_d = NVM_ST_RACK;
                    end
                end
                NVM_ST_RACK: begin
                    if (scl_fall) begin
                        oe_d = 1'b0;
                    end
                    if (scl_rise) begin
                        state_d = pins.sda ? NVM_ST_IDLE : NVM_ST_RLOAD;
                    end
                end
                NVM_ST_RLOAD: begin
                    if (scl_fall) begin
                        cnt_d   = `NVM_CNT_RST;
                        tx_d    = rd_data;
                        oe_d    = ~rd_data[DATA_W-1];
                        state_d = NVM_ST_RDATA;
                    end
                end
                default: begin
                    state_d = NVM_ST_IDLE;
                    oe_d    = 1'b0;
                end
            endcase
        end
    end

    // state registers; reset is the only initialisation
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= NVM_ST_IDLE;
            ret_q   <= NVM_ST_IDLE;
            cnt_q   <= `NVM_CNT_RST;
            addr_q  <= `NVM_ADDR_RST;
            page_q  <= 1'b0;
            oe_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            ret_q   <= ret_d;
            cnt_q   <= cnt_d;
            addr_q  <= addr_d;
            page_q  <= page_d;
            oe_q    <= oe_d;
        end
    end

    // data shifters
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            shift_q <= '0;
            tx_q    <= '0;
        end else begin
            shift_q <= shift_d;
            tx_q    <= tx_d;
        end
    end

    // storage array, written in the cycle the byte completes
    nvm_mem #(
        .DEPTH   (DEPTH),
        .ADDR_W  (ADDR_W),
        .DATA_W  (DATA_W)
    ) u_mem (
        .clk     (clk),
        .wr_en   (wr.en),
        .wr_addr (wr.addr),
        .wr_data (wr.data),
        .rd_addr (addr_q),
        .rd_data (rd_data)
    );

    // open drain: level is always low, only the enable moves
    assign sda_out = 1'b0;
    assign sda_oe  = oe_q;

endmodule

/* File: tb/nvm_slave_properties.sv */
/* checker of the memory slave pins: acknowledge, release and drive timing.
   assumes binding to nvm_slave and a serial clock half period of 4 clk or more. */
`timescale 1ns/1ps

module nvm_slave_properties #(
    parameter logic [3:0] DEV_TYPE = 4'h5  // value arbitrary
) (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic       wp_in,
    input wire logic [1:0] device_select_pins
);
    logic       scl_q, sda_q, first_q, rd_q, hit_q;
    logic [3:0] cnt_q, lo_q;
    logic [6:0] sh_q;
    // bus conditions seen on the pins
    wire        rise  = scl_in & ~scl_q;
    wire        start = scl_in & scl_q & sda_q & ~sda_in;
    wire        stop  = scl_in & scl_q & ~sda_q & sda_in;
    wire        ninth = rise & (cnt_q == 4'h8);
    wire [7:0]  abyte = {sh_q, sda_in};
    wire        wr_ack = ninth & ~first_q & ~rd_q & hit_q;
    wire        rd_ack = ninth & ~first_q & rd_q & hit_q;

    // bit count, slave byte capture, cycles since scl fell
    always_ff @(posedge clk) begin
        scl_q <= scl_in;
        sda_q <= sda_in;
        lo_q  <= (scl_q & ~scl_in) ? 4'h0 : ((lo_q == 4'hF) ? lo_q : lo_q + 4'h1);
        if (sys_rst | start) begin
            cnt_q   <= 4'h0;
            first_q <= 1'b1;
        end else if (rise) begin
            cnt_q   <= ninth ? 4'h0 : cnt_q + 4'h1;
            sh_q    <= abyte[6:0];
            first_q <= first_q & ~ninth;
            if (first_q && cnt_q == 4'h7) begin
                hit_q <= (abyte[7:4] == DEV_TYPE) && (abyte[3:2] == device_select_pins);
                rd_q  <= sda_in;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_out_low: assert property (sda_out == 1'b0)
        else $error("sda_out not low");
    a_rst_idle: assert property (disable iff (1'b0) sys_rst |=> !sda_oe)
        else $error("sda_oe high after reset");
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in && lo_q <= 4'h4)
        else $error("sda_oe moved outside scl low");
    a_addr_ack: assert property (ninth && first_q |-> sda_oe == hit_q)
        else $error("slave byte ack wrong");
    a_write_ack: assert property (wr_ack |-> sda_oe)
        else $error("write byte not acked");
    a_read_release: assert property (rd_ack |-> !sda_oe)
        else $error("read ack slot driven");
    a_nack_idle: assert property (rd_ack && sda_in |=> !sda_oe [*8])
        else $error("drive after nack");
    a_stop_quiet: assert property (stop |-> ##1 !sda_oe [*6])
        else $error("drive after stop");
    a_quiet_unsel: assert property (!first_q && !hit_q |-> !sda_oe)
        else $error("unselected device drives");

    c_refused: cover property (ninth && first_q && !hit_q);
    c_nack: cover property (rd_ack && sda_in);
    c_prot_wr: cover property (wr_ack && wp_in);
endmodule

/* File: tb/nvm_master.sv */
/* bus master model: start, stop and byte transfers on the serial pins.
   assumes an external pull-up, so a released data line reads high. */
`timescale 1ns/1ps

module nvm_master (
    input  wire logic clk,
    input  wire logic sda_in,
    output logic      scl,
    output logic      sda_low
);
    // clock stands high and data released outside frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one bit: change in the low phase, sample mid high phase
    task automatic bit_io(input logic b, output logic r);
        wt(1);
        sda_low <= ~b;
        wt(3);
        scl <= 1'b1;
        wt(2);
        r = sda_in;
        wt(2);
        scl <= 1'b0;
    endtask

    task automatic start();
        sda_low <= 1'b0;
        scl <= 1'b1;
        wt(4);
        sda_low <= 1'b1;
        wt(4);
        scl <= 1'b0;
    endtask

    task automatic stop();
        wt(1);
        sda_low <= 1'b1;
        wt(3);
        scl <= 1'b1;
        wt(4);
        sda_low <= 1'b0;
        wt(4);
    endtask

    // msb first, then the slave's acknowledge
    task automatic byte_tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    // release for 8 bits, then ack or, on the last byte, no ack
    task automatic byte_rx(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask
endmodule

/* File: tb/tb_top.sv */
/* self-checking bench of the memory slave: selection, writes, reads, wrap, protect.
   assumes nvm_slave, nvm_master and the checker are compiled before it. */
`timescale 1ns/1ps

module tb_top;
    localparam logic [3:0] DT = 4'h6;  // device type, value arbitrary
    localparam int LIMIT = 60000;
    logic       clk, sys_rst, wp_in, scl, m_low, sda_out, sda_oe, ack;
    logic [1:0] pins;
    logic [8:0] a;
    logic [7:0] mem [512];
    bit         known [512];
    logic [31:0] seed;
    int         fail_count, comparisons, cycles, n;
    // wired-and data line with pull-up
    wire        sda = ~((sda_oe & ~sda_out) | m_low);

    nvm_slave #(.DEV_TYPE(DT)) u_nvm_slave (.clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .wp_in(wp_in), .device_select_pins(pins));
    nvm_master u_nvm_master (.clk(clk), .sda_in(sda), .scl(scl), .sda_low(m_low));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic hdr(input logic [8:0] ad, input logic rw);
        u_nvm_master.start();
        u_nvm_master.byte_tx({DT, pins, ad[8], rw}, ack);
    endtask

    // write n random bytes from ad on, mirror unless protected
    task automatic wr(input logic [8:0] ad, input int n);
        logic [7:0] d;
        hdr(ad, 1'b0);
        u_nvm_master.byte_tx(ad[7:0], ack);
        chk("word ack", 8'(ack), 8'h01);
        for (int i = 0; i < n; i++) begin
            seed = lfsr(seed);
            d = seed[7:0];
            u_nvm_master.byte_tx(d, ack);
            chk("data ack", 8'(ack), 8'h01);
            if (!wp_in) begin
                mem[ad] = d;
                known[ad] = 1'b1;
            end
            ad = ad + 9'h001;
        end
        u_nvm_master.stop();
    endtask

    // read n bytes from ad, loading the latch first when set
    task automatic rd(input logic [8:0] ad, input int n, input logic set);
        logic [7:0] d;
        if (set) begin
            hdr(ad, 1'b0);
            u_nvm_master.byte_tx(ad[7:0], ack);
            u_nvm_master.stop();
        end
        hdr(ad, 1'b1);
        chk("read ack", 8'(ack), 8'h01);
        for (int i = 0; i < n; i++) begin
            u_nvm_master.byte_rx(i == n - 1, d);
            if (known[ad]) chk("read data", d, mem[ad]);
            ad[7:0] = ad[7:0] + 8'h01;
        end
        u_nvm_master.stop();
        chk("released", 8'(sda_oe), 8'h00);
    endtask

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            stop_test();
        end
    end

    initial begin
        sys_rst = 1'b1;
        wp_in = 1'b0;
        pins = 2'b00;
        seed = 32'h8A7712FC;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk("idle oe", 8'(sda_oe), 8'h00);
        // every select value against every pin setting, plus a foreign type
        for (int s = 0; s < 4; s++) begin
            pins <= 2'(s);
            for (int k = 0; k < 5; k++) begin
                u_nvm_master.start();
                u_nvm_master.byte_tx({(k == 4) ? 4'h3 : DT, 2'(k), 2'b00}, ack);
                u_nvm_master.stop();
                chk("sel ack", 8'(ack), 8'(k == s));
            end
        end
        pins <= 2'b10;
        // wrap from the last location to zero
        wr(9'h1FE, 3);
        rd(9'h1FE, 2, 1'b1);
        rd(9'h000, 1, 1'b1);
        // protected write: acked, latch moves on, data kept
        wr(9'h0A0, 2);
        wp_in <= 1'b1;
        wr(9'h0A0, 1);
        rd(9'h0A1, 1, 1'b0);
        wp_in <= 1'b0;
        rd(9'h0A0, 1, 1'b1);
        // random bursts: open pass first so no unwritten cell is driven, then a
        // second pass under random protect, read back at once
        repeat (12) begin
            seed = lfsr(seed);
            a = seed[8:0];
            n = 1 + seed[11:10];
            if (a[7:0] > 8'hF8) a[7:0] = 8'hF8;
            wp_in <= 1'b0;
            wr(a, n);
            wp_in <= seed[12];
            wr(a, n);
            wp_in <= 1'b0;
            rd(a, n, 1'b1);
        end
        stop_test();
    end
endmodule

bind nvm_slave nvm_slave_properties #(.DEV_TYPE(DEV_TYPE)) u_nvm_slave_properties (.clk(clk),
    .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .wp_in(wp_in), .device_select_pins(device_select_pins));
